// >>> sysfh_pkg.sv
// What this block does
// - balancing hold forces switches off, counters run
// - diagnostic flag reads one only in diagnostic
// - soft reset bit pulses reset, survives it
// - waveform select zero: fault pin static level
// - heartbeat when fault-free, high phase 500 us
// - off-time field picks 500us/1/10/100 ms low
// - silence beyond selected period sets comm-loss flag
package sysfh_pkg;
	localparam int CLK_HZ    = 20_000_000;
	localparam int US_PER_S  = 1_000_000;
	localparam int US_PER_MS = 1000;
	// one enable pulse per microsecond
	localparam int TICK_CYC  = CLK_HZ / US_PER_S;

	localparam int HB_HIGH_US = 500;
	localparam int HB_OFF0_US = 500;
	localparam int HB_OFF1_MS = 1;
	localparam int HB_OFF2_MS = 10;
	localparam int HB_OFF3_MS = 100;
	localparam int COMM0_MS   = 32;
	localparam int COMM1_MS   = 64;
	localparam int COMM2_MS   = 128;
	localparam int COMM3_MS   = 256;
	localparam int CNT_W      = 20;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_SETUP_ONE = 7'h03;
	localparam logic [ADDR_W-1:0] ADDR_SETUP_TWO = 7'h04;

	localparam int ONE_DIAG_BIT = 6;
	localparam int ONE_HOLD_BIT = 5;
	localparam int ONE_SRST_BIT = 4;
	localparam int ONE_WAVE_BIT = 3;
	localparam int ONE_OFF_LSB  = 1;
	localparam logic [DATA_W-1:0] ONE_RESET = 16'h1001;
	localparam logic [DATA_W-1:0] ONE_WMASK = 16'hFFAF;

	localparam int TWO_PRIOR_LSB = 10;
	localparam int TWO_TMO_LSB   = 8;
	localparam logic [DATA_W-1:0] TWO_RESET = 16'h0398;
	localparam logic [DATA_W-1:0] TWO_WMASK = 16'h03FF;

	typedef enum logic [2:0] {
		DEV_INIT   = 3'h0,
		DEV_IDLE   = 3'h1,
		DEV_NORMAL = 3'h2,
		DEV_DIAG   = 3'h3,
		DEV_WAKE   = 3'h6,
		DEV_SLEEP  = 3'h7
	} sysfh_dev_state_e;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sysfh_reg_req_s;
endpackage

// >>> sysfh_heartbeat.sv
`timescale 1ns/1ns
module sysfh_heartbeat #(
	parameter int HIGH_US = sysfh_pkg::HB_HIGH_US,
	parameter int OFF0_US = sysfh_pkg::HB_OFF0_US,
	parameter int OFF1_US = sysfh_pkg::HB_OFF1_MS * sysfh_pkg::US_PER_MS,
	parameter int OFF2_US = sysfh_pkg::HB_OFF2_MS * sysfh_pkg::US_PER_MS,
	parameter int OFF3_US = sysfh_pkg::HB_OFF3_MS * sysfh_pkg::US_PER_MS
) (
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	// control
	input  wire logic       tick_i,
	input  wire logic       wave_sel_i,
	input  wire logic [1:0] off_sel_i,
	input  wire logic       fault_i,
	// pin level
	output logic            fault_pin_o
);
	import sysfh_pkg::*;

	typedef enum logic [1:0] {
		HB_HIGH = 2'h1,
		HB_LOW  = 2'h2
	} sysfh_hb_e;

	sysfh_hb_e           phase;
	sysfh_hb_e           next_phase;
	logic [CNT_W-1:0]    cnt;
	logic [CNT_W-1:0]    next_cnt;
	logic                next_pin;

	function automatic logic [CNT_W-1:0] off_limit(input logic [1:0] sel);
		case (sel)
			2'h0:    off_limit = CNT_W'(OFF0_US);
			2'h1:    off_limit = CNT_W'(OFF1_US);
			2'h2:    off_limit = CNT_W'(OFF2_US);
			default: off_limit = CNT_W'(OFF3_US);
		endcase
	endfunction

	wire [CNT_W-1:0] high_lim = CNT_W'(HIGH_US);
	wire [CNT_W-1:0] low_lim  = off_limit(off_sel_i);
	wire             run      = wave_sel_i && !fault_i;
	wire             last_hi  = tick_i && (cnt >= high_lim - CNT_W'(1));
	wire             last_lo  = tick_i && (cnt >= low_lim - CNT_W'(1));

	always_comb begin
		next_phase = phase;
		next_cnt   = cnt;
		if (!run) begin
			// restart from a fresh high phase once the wave resumes
			next_phase = HB_HIGH;
			next_cnt   = '0;
		end else begin
			unique case (phase)
				HB_HIGH: begin
					if (last_hi) begin
						next_phase = HB_LOW;
						next_cnt   = '0;
					end else if (tick_i) begin
						next_cnt = cnt + CNT_W'(1);
					end
				end
				HB_LOW: begin
					if (last_lo) begin
						next_phase = HB_HIGH;
						next_cnt   = '0;
					end else if (tick_i) begin
						next_cnt = cnt + CNT_W'(1);
					end
				end
				default: begin
					next_phase = HB_HIGH;
					next_cnt   = '0;
				end
			endcase
		end
	end

	// static level, fault override, or wave phase
	assign next_pin = !wave_sel_i ? fault_i :
		(fault_i || phase == HB_HIGH);

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			phase       <= HB_HIGH;
			cnt         <= '0;
			fault_pin_o <= 1'b0;
		end else begin
			phase       <= next_phase;
			cnt         <= next_cnt;
			fault_pin_o <= next_pin;
		end
	end

	chk_high_bound: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(run && phase == HB_HIGH) |-> cnt < high_lim)
		else $error("heartbeat high phase overran");
	chk_low_bound: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(run && phase == HB_LOW && $stable(off_sel_i)) |-> cnt < low_lim)
		else $error("heartbeat low phase overran");
	chk_high_ends: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(run && phase == HB_HIGH && last_hi) |=> (phase == HB_LOW || !$past(run)))
		else $error("heartbeat high phase did not end");
	cov_low_phase: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		run && phase == HB_LOW ##1 phase == HB_HIGH);
endmodule

// >>> sysfh_top.sv
`timescale 1ns/1ns
module sysfh_top #(
	parameter int NUM_CELLS = 14,
	parameter int TICK_CYC  = sysfh_pkg::TICK_CYC,
	// microseconds that one tick stands for; every time limit is divided by it
	parameter int US_PER_TICK = 1,
	parameter int HIGH_US   = sysfh_pkg::HB_HIGH_US,
	parameter int OFF0_US   = sysfh_pkg::HB_OFF0_US,
	parameter int OFF1_US   = sysfh_pkg::HB_OFF1_MS * sysfh_pkg::US_PER_MS,
	parameter int OFF2_US   = sysfh_pkg::HB_OFF2_MS * sysfh_pkg::US_PER_MS,
	parameter int OFF3_US   = sysfh_pkg::HB_OFF3_MS * sysfh_pkg::US_PER_MS,
	parameter int COMM0_US  = sysfh_pkg::COMM0_MS * sysfh_pkg::US_PER_MS,
	parameter int COMM1_US  = sysfh_pkg::COMM1_MS * sysfh_pkg::US_PER_MS,
	parameter int COMM2_US  = sysfh_pkg::COMM2_MS * sysfh_pkg::US_PER_MS,
	parameter int COMM3_US  = sysfh_pkg::COMM3_MS * sysfh_pkg::US_PER_MS
) (
	// clock and power-on reset
	input  wire logic                          sys_clk_i,
	input  wire logic                          reset_i,
	// register access from the host link
	input  wire sysfh_pkg::sysfh_reg_req_s     reg_req_i,
	output logic [sysfh_pkg::DATA_W-1:0]       reg_rdata_o,
	// device state and events
	input  wire sysfh_pkg::sysfh_dev_state_e   device_state_i,
	input  wire logic                          fault_present_i,
	input  wire logic                          comm_activity_i,
	input  wire logic                          comm_loss_clr_i,
	// balancing switches
	input  wire logic [NUM_CELLS-1:0]          cb_switch_req_i,
	output logic [NUM_CELLS-1:0]               cb_switch_o,
	// outputs
	output logic                               fault_pin_o,
	output logic                               comm_loss_o,
	output logic                               soft_reset_o
);
	import sysfh_pkg::*;

	localparam int TW = $clog2(TICK_CYC + 1);

	logic [DATA_W-1:0]      setup_one;
	logic                   srst_bit;
	logic [DATA_W-1:0]      setup_two;
	sysfh_dev_state_e       last_state;
	sysfh_dev_state_e       prior_state;
	logic [TW-1:0]          tick_cnt;
	logic                   tick;
	logic [CNT_W-1:0]       silence_cnt;
	logic [CNT_W-1:0]       next_silence;
	logic [DATA_W-1:0]      next_rdata;

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [DATA_W-1:0] mask);
		merge = (old_v & ~mask) | (new_v & mask);
	endfunction

	function automatic logic [CNT_W-1:0] comm_limit(input logic [1:0] sel);
		case (sel)
			2'h0:    comm_limit = CNT_W'(COMM0_US / US_PER_TICK);
			2'h1:    comm_limit = CNT_W'(COMM1_US / US_PER_TICK);
			2'h2:    comm_limit = CNT_W'(COMM2_US / US_PER_TICK);
			default: comm_limit = CNT_W'(COMM3_US / US_PER_TICK);
		endcase
	endfunction

	// decode
	wire wr_one   = reg_req_i.wr && reg_req_i.addr == ADDR_SETUP_ONE;
	wire wr_two   = reg_req_i.wr && reg_req_i.addr == ADDR_SETUP_TWO;
	wire rd_one   = reg_req_i.rd && reg_req_i.addr == ADDR_SETUP_ONE;
	wire rd_two   = reg_req_i.rd && reg_req_i.addr == ADDR_SETUP_TWO;
	wire srst_req = wr_one && reg_req_i.wdata[ONE_SRST_BIT];
	// the soft reset pulse clears the whole block except its own bit and the prior_state/last_state record
	wire core_rst = reset_i || soft_reset_o;

	wire       hold_sel  = setup_one[ONE_HOLD_BIT];
	wire       wave_sel  = setup_one[ONE_WAVE_BIT];
	wire [1:0] off_sel   = setup_one[ONE_OFF_LSB +: 2];
	wire [1:0] tmo_sel   = setup_two[TWO_TMO_LSB +: 2];
	wire       diag_flag = device_state_i == DEV_DIAG;
	wire [CNT_W-1:0] silence_lim = comm_limit(tmo_sel);
	wire       silence_hit = tick && (silence_cnt >= silence_lim - CNT_W'(1));

	wire [DATA_W-1:0] one_view = {setup_one[DATA_W-1:ONE_DIAG_BIT+1], diag_flag,
		setup_one[ONE_HOLD_BIT], srst_bit, setup_one[ONE_SRST_BIT-1:0]};
	wire [DATA_W-1:0] two_view = {setup_two[DATA_W-1:TWO_PRIOR_LSB+3], prior_state,
		setup_two[TWO_PRIOR_LSB-1:0]};

	assign next_rdata = rd_one ? one_view : rd_two ? two_view : '0;
	// activity restarts the window, otherwise it runs once per tick
	assign next_silence = comm_activity_i ? '0 :
		silence_hit ? '0 : tick ? silence_cnt + CNT_W'(1) : silence_cnt;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			srst_bit    <= 1'b0;
			prior_state <= DEV_INIT;
			last_state  <= DEV_INIT;
		end else begin
			// survives its own reset pulse, only power-on or a setup_one write with the bit at zero clears it
			if (wr_one) begin
				srst_bit <= reg_req_i.wdata[ONE_SRST_BIT];
			end
			last_state <= device_state_i;
			if (device_state_i != last_state) begin
				prior_state <= last_state;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			soft_reset_o <= 1'b0;
		end else begin
			soft_reset_o <= srst_req && !soft_reset_o;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (core_rst) begin
			setup_one <= ONE_RESET;
			setup_two <= TWO_RESET;
		end else begin
			if (wr_one) begin
				setup_one <= merge(setup_one, reg_req_i.wdata, ONE_WMASK);
			end
			if (wr_two) begin
				setup_two <= merge(setup_two, reg_req_i.wdata, TWO_WMASK);
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (core_rst) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else begin
			tick     <= tick_cnt == TW'(TICK_CYC - 1);
			tick_cnt <= (tick_cnt == TW'(TICK_CYC - 1)) ? '0 : tick_cnt + TW'(1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (core_rst) begin
			silence_cnt <= '0;
			comm_loss_o <= 1'b0;
			cb_switch_o <= '0;
			reg_rdata_o <= '0;
		end else begin
			silence_cnt <= next_silence;
			// a timeout in the clearing cycle still sets the flag
			comm_loss_o <= (silence_hit && !comm_activity_i) ||
				(comm_loss_o && !comm_loss_clr_i);
			// switches gated only; balance timers elsewhere keep running
			cb_switch_o <= hold_sel ? '0 : cb_switch_req_i;
			reg_rdata_o <= next_rdata;
		end
	end

	// heartbeat counts ticks, so its limits are given in ticks
	sysfh_heartbeat #(
		.HIGH_US (HIGH_US / US_PER_TICK),
		.OFF0_US (OFF0_US / US_PER_TICK),
		.OFF1_US (OFF1_US / US_PER_TICK),
		.OFF2_US (OFF2_US / US_PER_TICK),
		.OFF3_US (OFF3_US / US_PER_TICK)
	) u_heartbeat (
		.sys_clk_i   (sys_clk_i),
		.reset_i     (core_rst),
		.tick_i      (tick),
		.wave_sel_i  (wave_sel),
		.off_sel_i   (off_sel),
		.fault_i     (fault_present_i),
		.fault_pin_o (fault_pin_o)
	);

	chk_hold_forces_off: assert property (@(posedge sys_clk_i) disable iff (core_rst)
		hold_sel |=> cb_switch_o == '0)
		else $error("balance switch on during hold");
	chk_switch_follows: assert property (@(posedge sys_clk_i) disable iff (core_rst)
		!hold_sel |=> cb_switch_o == $past(cb_switch_req_i))
		else $error("balance switch does not follow request");
	chk_diag_flag_read: assert property (@(posedge sys_clk_i) disable iff (core_rst)
		rd_one |=> reg_rdata_o[ONE_DIAG_BIT] == ($past(device_state_i) == DEV_DIAG))
		else $error("diagnostic flag read wrong");
	chk_srst_single_pulse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		srst_req && !soft_reset_o |=> soft_reset_o ##1 !soft_reset_o)
		else $error("soft reset not a single pulse");
	chk_srst_bit_kept: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		soft_reset_o |-> srst_bit ##1 srst_bit)
		else $error("soft reset bit lost in its own reset");
	chk_static_level: assert property (@(posedge sys_clk_i) disable iff (core_rst)
		!wave_sel |=> fault_pin_o == $past(fault_present_i))
		else $error("static fault level wrong");
	chk_fault_holds_high: assert property (@(posedge sys_clk_i) disable iff (core_rst)
		(wave_sel && fault_present_i) [*2] |=> fault_pin_o)
		else $error("fault pin not held high on fault");
	chk_prior_recorded: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(device_state_i != last_state) |=> prior_state == $past(last_state))
		else $error("prior state not recorded");
	chk_silence_sets_loss: assert property (@(posedge sys_clk_i) disable iff (core_rst)
		(silence_hit && !comm_activity_i) |=> comm_loss_o)
		else $error("comm loss flag not set at timeout");
	chk_silence_bound: assert property (@(posedge sys_clk_i) disable iff (core_rst)
		$stable(tmo_sel) |-> silence_cnt < silence_lim)
		else $error("silence counter passed its limit");

	cov_comm_loss: cover property (@(posedge sys_clk_i) disable iff (core_rst)
		!comm_loss_o ##1 comm_loss_o);
	cov_soft_reset: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		soft_reset_o);
	cov_fault_in_wave: cover property (@(posedge sys_clk_i) disable iff (core_rst)
		wave_sel && !fault_present_i ##1 fault_present_i);
	cov_prior_diag: cover property (@(posedge sys_clk_i) disable iff (reset_i)
		prior_state == DEV_DIAG);
endmodule

// >>> sysfh_host_model.sv
`timescale 1ns/1ns
module sysfh_host_model (
	// clock
	input  wire logic                         sys_clk_i,
	// register link
	output sysfh_pkg::sysfh_reg_req_s         reg_req_o,
	input  wire logic [sysfh_pkg::DATA_W-1:0] reg_rdata_i,
	// traffic marker
	output logic                              comm_activity_o
);
	import sysfh_pkg::*;

	initial begin
		reg_req_o = '0;
		comm_activity_o = 1'b0;
	end

	// every access counts as traffic, so regular polling keeps the silence timer quiet
	task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
			input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
		@(posedge sys_clk_i);
		reg_req_o <= '{wr: wr, rd: !wr, addr: a, wdata: d};
		comm_activity_o <= 1'b1;
		@(posedge sys_clk_i);
		reg_req_o <= '0;
		comm_activity_o <= 1'b0;
		#1;
		q = reg_rdata_i;
	endtask
endmodule

// >>> tb.sv
`timescale 1ns/1ns
module tb;
	import sysfh_pkg::*;
	logic              sys_clk_i;
	logic              reset_i;
	logic              fault_present_i;
	logic              comm_loss_clr_i;
	logic              comm_activity_i;
	sysfh_reg_req_s    reg_req_i;
	sysfh_dev_state_e  device_state_i;
	sysfh_dev_state_e  prev;
	logic [DATA_W-1:0] reg_rdata_o;
	logic [DATA_W-1:0] q;
	logic [13:0]       cb_switch_req_i;
	logic [13:0]       cb_switch_o;
	logic              fault_pin_o;
	logic              comm_loss_o;
	logic              soft_reset_o;
	int                num_errors;
	int                n_compared;
	int                hi;
	int                lo;
	int                n;
	sysfh_dev_state_e  seq [6] = '{DEV_IDLE, DEV_NORMAL, DEV_DIAG, DEV_WAKE, DEV_SLEEP, DEV_INIT};
	// one tick per cycle, each worth a hundred microseconds, keeps runs short
	localparam int     SCALE = 100;
	localparam int     HI_LEN = HB_HIGH_US / SCALE;
	int                off_len [4] = '{HB_OFF0_US / SCALE, HB_OFF1_MS * US_PER_MS / SCALE,
		HB_OFF2_MS * US_PER_MS / SCALE, HB_OFF3_MS * US_PER_MS / SCALE};
	int                sil_len [4] = '{COMM0_MS * US_PER_MS / SCALE, COMM1_MS * US_PER_MS / SCALE,
		COMM2_MS * US_PER_MS / SCALE, COMM3_MS * US_PER_MS / SCALE};

	always #25 sys_clk_i = ~sys_clk_i;

	sysfh_top #(.TICK_CYC(1), .US_PER_TICK(SCALE)) u_sysfh_top (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i),
		.reg_rdata_o(reg_rdata_o), .device_state_i(device_state_i),
		.fault_present_i(fault_present_i), .comm_activity_i(comm_activity_i),
		.comm_loss_clr_i(comm_loss_clr_i), .cb_switch_req_i(cb_switch_req_i),
		.cb_switch_o(cb_switch_o), .fault_pin_o(fault_pin_o),
		.comm_loss_o(comm_loss_o), .soft_reset_o(soft_reset_o));

	sysfh_host_model u_sysfh_host_model (.sys_clk_i(sys_clk_i), .reg_req_o(reg_req_i),
		.reg_rdata_i(reg_rdata_o), .comm_activity_o(comm_activity_i));

	task automatic finish_test();
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		u_sysfh_host_model.access(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [6:0] a);
		u_sysfh_host_model.access(1'b0, a, 16'h0000, q);
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk_i);
		#1;
	endtask

	// counts cycles until the pin shows lvl; bounded so a stuck pin ends the run
	task automatic wait_pin(input logic lvl, output int len);
		len = 0;
		while (fault_pin_o !== lvl) begin
			cyc(1);
			len++;
			if (len > 2000) begin
				num_errors++;
				finish_test();
			end
		end
	endtask

	initial begin
		sys_clk_i = 1'b0;
		reset_i = 1'b1;
		fault_present_i = 1'b0;
		comm_loss_clr_i = 1'b0;
		device_state_i = DEV_INIT;
		cb_switch_req_i = 14'h3FFF;
		num_errors = 0;
		n_compared = 0;
		prev = DEV_INIT;
		repeat (20) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(ADDR_SETUP_ONE);
		check("setup_one reset", ONE_RESET, q);
		cyc(1);
		check("read data stands one cycle", 16'h0000, reg_rdata_o);
		rd(ADDR_SETUP_TWO);
		check("setup_two reset", TWO_RESET, q);
		rd(7'h05);
		check("unmapped read", 16'h0000, q);
		wr(7'h05, 16'hFFFF);
		rd(ADDR_SETUP_ONE);
		check("setup_one after stray write", ONE_RESET, q);
		wr(ADDR_SETUP_ONE, 16'h0020);
		cyc(2);
		check("cb switches held", 16'h0000, {2'b00, cb_switch_o});
		wr(ADDR_SETUP_ONE, 16'h0040);
		cyc(2);
		check("cb switches free", 16'h3FFF, {2'b00, cb_switch_o});
		rd(ADDR_SETUP_ONE);
		check("diag bit read-only", 16'h0000, q);
		foreach (seq[i]) begin
			@(posedge sys_clk_i) device_state_i <= seq[i];
			rd(ADDR_SETUP_TWO);
			check("prior state", {13'h0000, prev}, {13'h0000, q[12:10]});
			rd(ADDR_SETUP_ONE);
			check("diag flag", {15'h0000, seq[i] == DEV_DIAG}, {15'h0000, q[6]});
			prev = seq[i];
		end
		wr(ADDR_SETUP_TWO, 16'hFC00);
		rd(ADDR_SETUP_TWO);
		check("prior state read-only", 16'h1C00, q);
		@(posedge sys_clk_i) fault_present_i <= 1'b1;
		cyc(2);
		check("static pin fault", 16'h0001, {15'h0000, fault_pin_o});
		@(posedge sys_clk_i) fault_present_i <= 1'b0;
		cyc(2);
		check("static pin clear", 16'h0000, {15'h0000, fault_pin_o});
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_SETUP_ONE, {12'h000, 1'b1, 2'(k), 1'b0});
			wait_pin(1'b0, n);
			wait_pin(1'b1, n);
			wait_pin(1'b0, hi);
			wait_pin(1'b1, lo);
			check("hb high", 16'h0001, {15'h0000, hi >= HI_LEN - 1 && hi <= HI_LEN + 1});
			check("hb low", 16'h0001, {15'h0000, lo >= off_len[k] - 1 && lo <= off_len[k] + 1});
		end
		@(posedge sys_clk_i) fault_present_i <= 1'b1;
		cyc(2);
		n = 0;
		repeat (30) begin
			if (fault_pin_o !== 1'b1)
				n++;
			cyc(1);
		end
		check("hb stopped by fault", 16'h0000, 16'(n));
		@(posedge sys_clk_i) fault_present_i <= 1'b0;
		cyc(2);
		check("hb restarts high", 16'h0001, {15'h0000, fault_pin_o});
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_SETUP_TWO, {6'h00, 2'(k), 8'h98});
			@(posedge sys_clk_i) comm_loss_clr_i <= 1'b1;
			@(posedge sys_clk_i) comm_loss_clr_i <= 1'b0;
			#1;
			n = 0;
			while (comm_loss_o !== 1'b1) begin
				cyc(1);
				n++;
				if (n > 3000) begin
					num_errors++;
					finish_test();
				end
			end
			check("silence period", 16'h0001, {15'h0000, n >= sil_len[k] - 4 && n <= sil_len[k] + 1});
			cyc(5);
			check("comm loss sticky", 16'h0001, {15'h0000, comm_loss_o});
		end
		wr(ADDR_SETUP_ONE, 16'h0010);
		check("soft reset pulse", 16'h0001, {15'h0000, soft_reset_o});
		cyc(1);
		check("soft reset single", 16'h0000, {15'h0000, soft_reset_o});
		rd(ADDR_SETUP_ONE);
		check("setup_one after soft reset", ONE_RESET | 16'h0010, q);
		rd(ADDR_SETUP_TWO);
		check("setup_two after soft reset", 16'h1F98, q);
		@(posedge sys_clk_i) reset_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(ADDR_SETUP_ONE);
		check("setup_one after power-on reset", ONE_RESET, q);
		finish_test();
	end
endmodule
